/* File: src/betd_map.svh */
// Constants of the band extension transient detector: offsets, fields, resets and counts
`ifndef BETD_MAP_SVH
`define BETD_MAP_SVH

// Register offsets
`define BETD_OFS_CTRL      4'h0
`define BETD_OFS_STATUS    4'h4
`define BETD_OFS_FB_ORI    4'h8
`define BETD_OFS_FB_SYN    4'hC
`define BETD_CTRL_RESET    32'h0000_0000

// Control field positions
`define BETD_CTRL_RATE_LSB 0
`define BETD_CTRL_BW_LSB   3
`define BETD_CTRL_INACTIVE 5
`define BETD_CTRL_HINT_LSB 6

// Rate codes and bandwidth codes
`define BETD_RATE_7K2      3'h0
`define BETD_RATE_8K0      3'h1
`define BETD_RATE_13K2     3'h2
`define BETD_RATE_32K0     3'h3
`define BETD_BW_WB         2'h0
`define BETD_BW_SWB        2'h1
`define BETD_BW_FB         2'h2

// Frame geometry
`define BETD_UB_FRAME_LEN  9'h140
`define BETD_UB_SUB_LEN    7'h50
`define BETD_LB_FRAME_LEN  9'h100
`define BETD_LB_SUB_LEN    7'h40

// Filter coefficients in Q14 and decision thresholds
`define BETD_HP_POLE       18'sh01F8F
`define BETD_HP_ZERO       18'sh02FA8
`define BETD_HP_SHIFT      14
`define BETD_RHO2_INACTIVE 56'h14
`define BETD_RHO2_ACTIVE   56'h1B
`define BETD_LF_RATIO2     56'h0B
`define BETD_TILT_SQ       56'h40

// Bit budget
`define BETD_BUDGET_TOTAL  5'h1F
`define BETD_BUDGET_CLASS  2'h2
`define BETD_ENV_TS_SPEC   4'h4
`define BETD_ENV_TS_TIME   3'h4
`define BETD_ENV_NT_SPEC   4'hE
`define BETD_FB_RATIO_MAX  4'hF

`endif

/* File: src/betd_pkg.sv */
// Types of the band extension transient detector
package betd_pkg;

    // One sample of a stream
    typedef struct packed {
        logic               valid;
        logic signed [15:0] data;
    } betd_sample_t;

    // Extension variant chosen by bit rate
    typedef enum logic [1:0] {
        BETD_VAR_NONE,
        BETD_VAR_BLIND_WB,
        BETD_VAR_GUIDED_WB,
        BETD_VAR_GUIDED_SWB
    } betd_variant_t;

    // Two-bit class codes
    typedef enum logic [1:0] {
        BETD_NOISE_CLASS     = 2'h0,
        BETD_TRANSIENT_CLASS = 2'h1,
        BETD_NORMAL_CLASS    = 2'h2,
        BETD_HARMONIC_CLASS  = 2'h3
    } betd_class_t;

    // Frame phase
    typedef enum logic [0:0] {
        BETD_COLLECT,
        BETD_DECIDE
    } betd_phase_t;

    // Frame result and budget
    typedef struct packed {
        logic        upper_band_transient_flag;
        logic        low_band_transient_flag;
        logic        tilt_veto;
        logic        hangover;
        betd_class_t frame_class;
        logic [4:0]  total_bits;
        logic [1:0]  class_bits;
        logic [3:0]  spectral_envs;
        logic [2:0]  time_envs;
        logic [3:0]  fullband_ratio;
    } betd_result_t;

endpackage : betd_pkg

/* File: src/betd_detector.sv */
// Band extension front end: high-pass, transient detection, tilt, class and budget
`timescale 1ns/1ns
`include "betd_map.svh"

// Functional notes
// - Bit rate and bandwidth select blind wideband, guided wideband or guided four-class variant.
// - Upper band is delayed by core delay minus extension delay before transform.
// - Super-wideband extension spends 31 bits per frame, two carrying the class.
// - Transient frames spend remaining 29 bits on four spectral and four time envelopes.
// - Other frames spend remaining bits on fourteen spectral envelopes, no time envelope.
// - Frame is transient when current or preceding frame detected an upper-band transient.
// - Fullband sends quantized energy ratio of two upper bands in four bits.
// - Delayed high-passed upper band feeds a 640-point transform downstream.
// - First-order high-pass: 0.4931 previous output plus 0.7446 input difference.
// - 320-sample frames split into four 80-sample sub-frames, energy is sum of squares.
// - Long-term energy is 0.75 old plus 0.25 sub-frame energy, carried across frames.
// - On algorithm or configuration change, prior long-term energy is samples 0..79 energy.
// - Filter memory and last long-term energy are kept across frames.
// - Transient when sub-frame energy exceeds 10 or 13.5 times prior long-term energy.
// - No transient when the previous frame did not use the four-class extension.
// - A detected transient also forces a transient indication in the next frame.
// - Tilt is r1 over square root of r0, r0 energy of 256 low-band samples.
// - r1 starts at first difference magnitude, adds magnitudes at sign reversals.
// - Transient with tilt above 8 is cleared and the hangover reset.
// - Low-band flag when a 64-sample sub-frame energy exceeds 5.5 times the preceding.
// - Class coded noise 00, transient 01, normal 10, harmonic 11, kept for next frame.
module betd_detector #(
    parameter int DELAY_SAMPLES = 16
) (
    // Clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_resetn,
    // Register port
    input  wire logic [3:0]            i_addr,
    input  wire logic [31:0]           i_wdata,
    input  wire logic                  i_wr,
    input  wire logic                  i_rd,
    output logic      [31:0]           o_rdata,
    // Sample streams
    input  wire betd_pkg::betd_sample_t i_upper,
    input  wire betd_pkg::betd_sample_t i_lower,
    // Delayed high-passed upper band for the transform
    output betd_pkg::betd_sample_t     o_mdct_in,
    // Frame result
    output logic                       o_frame_done,
    output betd_pkg::betd_variant_t    o_variant,
    output betd_pkg::betd_result_t     o_result
);

    // Control and fullband energy registers
    logic [31:0]            ctrl_r;
    logic [31:0]            fb_ori_r;
    logic [31:0]            fb_syn_r;
    logic [31:0]            rdata_r;
    // Upper band filter and energy state
    logic signed [15:0]     x_prev_r;
    logic signed [17:0]     y_prev_r;
    logic [8:0]             ub_cnt_r;
    logic [6:0]             ub_sub_r;
    logic [1:0]             ub_idx_r;
    logic [47:0]            ub_acc_r;
    logic [47:0]            lt_r;
    logic                   ub_det_r;
    logic                   ub_done_r;
    // Low band state
    logic [8:0]             lb_cnt_r;
    logic [6:0]             lb_sub_r;
    logic [47:0]            lb_acc_r;
    logic [47:0]            lb_prev_e_r;
    logic [47:0]            r0_r;
    logic [27:0]            r1_r;
    logic signed [15:0]     lx_prev_r;
    logic signed [16:0]     ld_prev_r;
    logic                   lb_det_r;
    logic                   lb_done_r;
    // Retained frame state
    logic                   hang_r;
    logic                   prev_swb_r;
    logic [4:0]             cfg_prev_r;
    betd_pkg::betd_class_t  class_prev_r;
    betd_pkg::betd_phase_t  phase_r;
    // Delay line
    logic signed [17:0]     dly_r [DELAY_SAMPLES];
    logic                   mdct_valid_r;
    logic signed [15:0]     mdct_data_r;
    // Outputs
    logic                   done_r;
    betd_pkg::betd_variant_t variant_r;
    betd_pkg::betd_result_t result_r;

    // Register decode
    wire sel_ctrl   = (i_addr == `BETD_OFS_CTRL);
    wire sel_status = (i_addr == `BETD_OFS_STATUS);
    wire sel_ori    = (i_addr == `BETD_OFS_FB_ORI);
    wire sel_syn    = (i_addr == `BETD_OFS_FB_SYN);
    wire [2:0] rate     = ctrl_r[`BETD_CTRL_RATE_LSB +: 3];
    wire [1:0] bw       = ctrl_r[`BETD_CTRL_BW_LSB +: 2];
    wire       inactive = ctrl_r[`BETD_CTRL_INACTIVE];
    wire [1:0] hint     = ctrl_r[`BETD_CTRL_HINT_LSB +: 2];
    wire [4:0] cfg_now  = {rate, bw};
    wire [31:0] status_word = {13'h0000, result_r.fullband_ratio, result_r.time_envs, result_r.spectral_envs,
                               variant_r, result_r.frame_class, result_r.hangover, result_r.tilt_veto,
                               result_r.low_band_transient_flag, result_r.upper_band_transient_flag};
    wire [31:0] rd_mux = sel_ctrl   ? ctrl_r :
                         sel_status ? status_word :
                         sel_ori    ? fb_ori_r :
                         sel_syn    ? fb_syn_r : 32'h0000_0000;

    // Variant selection by rate and bandwidth
    wire is_wb  = (bw == `BETD_BW_WB);
    wire is_swb = (bw == `BETD_BW_SWB) || (bw == `BETD_BW_FB);
    wire is_fb  = (bw == `BETD_BW_FB);
    betd_pkg::betd_variant_t variant_nxt;
    assign variant_nxt = (is_wb && (rate == `BETD_RATE_7K2 || rate == `BETD_RATE_8K0)) ?
                             betd_pkg::BETD_VAR_BLIND_WB :
                         (is_wb && rate == `BETD_RATE_13K2) ? betd_pkg::BETD_VAR_GUIDED_WB :
                         (is_swb && (rate == `BETD_RATE_13K2 || rate == `BETD_RATE_32K0)) ?
                             betd_pkg::BETD_VAR_GUIDED_SWB : betd_pkg::BETD_VAR_NONE;

    // High-pass filter in Q14
    wire signed [16:0] x_diff = 17'(i_upper.data) - 17'(x_prev_r);
    wire signed [35:0] hp_acc = (`BETD_HP_POLE * y_prev_r) + (`BETD_HP_ZERO * 18'(x_diff));
    wire signed [17:0] y_now  = hp_acc[`BETD_HP_SHIFT +: 18];
    wire [47:0] y_sq   = 48'(36'(y_now * y_now));
    wire        ub_sub_end = (ub_sub_r == `BETD_UB_SUB_LEN - 7'h01);
    wire [47:0] ub_e   = ub_acc_r + y_sq;
    wire        reinit = (ub_idx_r == 2'h0) && (cfg_now != cfg_prev_r);
    wire [47:0] lt_prior = reinit ? ub_e : lt_r;
    wire [47:0] lt_nxt = lt_prior - (lt_prior >> 2) + (ub_e >> 2);
    wire [55:0] rho2   = inactive ? `BETD_RHO2_INACTIVE : `BETD_RHO2_ACTIVE;
    wire        ub_hit = ({ub_e, 1'b0} + 56'h0) > (56'(lt_prior) * rho2);

    // Low band energy, tilt sums
    wire signed [16:0] ld_now = 17'(i_lower.data) - 17'(lx_prev_r);
    wire [16:0] ld_abs  = ld_now[16] ? 17'(-ld_now) : ld_now;
    wire [47:0] lx_sq   = 48'(32'(i_lower.data * i_lower.data));
    wire        lb_sub_end = (lb_sub_r == `BETD_LB_SUB_LEN - 7'h01);
    wire [47:0] lb_e    = lb_acc_r + lx_sq;
    wire        lb_hit  = ({lb_e, 1'b0} + 56'h0) > (56'(lb_prev_e_r) * `BETD_LF_RATIO2);
    wire        reversal = (ld_now != 17'sh0) && (ld_prev_r != 17'sh0) && (ld_now[16] != ld_prev_r[16]);
    wire [27:0] r1_nxt  = (lb_cnt_r == 9'h001) ? 28'(ld_abs) :
                          (lb_cnt_r >= 9'h002 && reversal) ? r1_r + 28'(ld_abs) : r1_r;
    // Tilt above 8 compared without a root: r1 squared against 64 r0
    wire [55:0] r1_sq   = 56'(r1_r) * 56'(r1_r);
    wire        tilt_veto = r1_sq > (56'(r0_r) * `BETD_TILT_SQ);

    // Frame decision
    wire det_now    = ub_det_r && prev_swb_r;
    wire trans_raw  = det_now || hang_r;
    wire trans_cut  = trans_raw && tilt_veto;
    wire is_trans   = trans_raw && !trans_cut && (variant_r == betd_pkg::BETD_VAR_GUIDED_SWB);
    wire hang_nxt   = trans_cut ? 1'b0 : det_now;
    wire hang_next  = trans_cut ? 1'b0 : hang_nxt;
    betd_pkg::betd_class_t class_nxt;
    assign class_nxt = is_trans ? betd_pkg::BETD_TRANSIENT_CLASS :
                       (variant_r != betd_pkg::BETD_VAR_GUIDED_SWB && hint != 2'h3) ?
                           betd_pkg::BETD_NORMAL_CLASS :
                       (hint == 2'h1) ? betd_pkg::BETD_NORMAL_CLASS : betd_pkg::betd_class_t'(hint);

    // Leading one position for the log ratio
    function automatic logic [5:0] msb_pos(input logic [31:0] v);
        logic [5:0] p;
        p = 6'h00;
        for (int i = 0; i < 32; i++) begin
            if (v[i]) begin
                p = 6'(i);
            end
        end
        return p;
    endfunction : msb_pos

    // Half the log2 of the energy ratio, clamped to four bits
    wire [6:0] log_diff = {1'b0, msb_pos(fb_ori_r)} - {1'b0, msb_pos(fb_syn_r)};
    wire [5:0] log_half = log_diff[6] ? 6'h00 : log_diff[6:1];
    wire [3:0] fb_q = (fb_syn_r == 32'h0) ? `BETD_FB_RATIO_MAX :
                      (log_half > 6'(`BETD_FB_RATIO_MAX)) ? `BETD_FB_RATIO_MAX : log_half[3:0];

    // Budget of the coming frame
    betd_pkg::betd_result_t result_nxt;
    always_comb begin
        result_nxt = '0;
        result_nxt.upper_band_transient_flag = is_trans;
        result_nxt.low_band_transient_flag   = lb_det_r;
        result_nxt.tilt_veto                 = tilt_veto;
        result_nxt.hangover                  = hang_next;
        result_nxt.frame_class               = class_nxt;
        if (variant_r == betd_pkg::BETD_VAR_GUIDED_SWB) begin
            result_nxt.total_bits = `BETD_BUDGET_TOTAL;
            result_nxt.class_bits = `BETD_BUDGET_CLASS;
            if (is_trans) begin
                result_nxt.spectral_envs = `BETD_ENV_TS_SPEC;
                result_nxt.time_envs     = `BETD_ENV_TS_TIME;
            end else begin
                result_nxt.spectral_envs = `BETD_ENV_NT_SPEC;
                result_nxt.time_envs     = 3'h0;
            end
            result_nxt.fullband_ratio = is_fb ? fb_q : 4'h0;
        end
    end

    // Register writes and read data one cycle later
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl_r   <= `BETD_CTRL_RESET;
            fb_ori_r <= 32'h0000_0000;
            fb_syn_r <= 32'h0000_0000;
            rdata_r  <= 32'h0000_0000;
        end else begin
            if (i_wr && sel_ctrl) ctrl_r <= i_wdata;
            if (i_wr && sel_ori) fb_ori_r <= i_wdata;
            if (i_wr && sel_syn) fb_syn_r <= i_wdata;
            rdata_r <= i_rd ? rd_mux : 32'h0000_0000;
        end
    end

    // Upper band filter, sub-frame energies, long-term energy
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            x_prev_r <= 16'sh0;
            y_prev_r <= 18'sh0;
            ub_cnt_r <= 9'h000;
            ub_sub_r <= 7'h00;
            ub_idx_r <= 2'h0;
            ub_acc_r <= 48'h0;
            lt_r     <= 48'h0;
            ub_det_r <= 1'b0;
            ub_done_r <= 1'b0;
        end else if (phase_r == betd_pkg::BETD_DECIDE) begin
            ub_done_r <= 1'b0;
            ub_det_r  <= 1'b0;
        end else if (i_upper.valid && !ub_done_r) begin
            x_prev_r <= i_upper.data;
            y_prev_r <= y_now;
            ub_acc_r <= ub_sub_end ? 48'h0 : ub_e;
            ub_sub_r <= ub_sub_end ? 7'h00 : ub_sub_r + 7'h01;
            if (ub_sub_end) begin
                lt_r     <= lt_nxt;
                ub_idx_r <= ub_idx_r + 2'h1;
                ub_det_r <= ub_det_r || ub_hit;
            end
            ub_cnt_r <= (ub_cnt_r == `BETD_UB_FRAME_LEN - 9'h001) ? 9'h000 : ub_cnt_r + 9'h001;
            ub_done_r <= (ub_cnt_r == `BETD_UB_FRAME_LEN - 9'h001);
        end
    end

    // Low band sub-frame energies and tilt sums
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            lb_cnt_r    <= 9'h000;
            lb_sub_r    <= 7'h00;
            lb_acc_r    <= 48'h0;
            lb_prev_e_r <= 48'h0;
            r0_r        <= 48'h0;
            r1_r        <= 28'h0;
            lx_prev_r   <= 16'sh0;
            ld_prev_r   <= 17'sh0;
            lb_det_r    <= 1'b0;
            lb_done_r   <= 1'b0;
        end else if (phase_r == betd_pkg::BETD_DECIDE) begin
            lb_done_r <= 1'b0;
            lb_det_r  <= 1'b0;
            r0_r      <= 48'h0;
            r1_r      <= 28'h0;
        end else if (i_lower.valid && !lb_done_r) begin
            lx_prev_r <= i_lower.data;
            ld_prev_r <= (lb_cnt_r == 9'h000) ? 17'sh0 : ld_now;
            r0_r      <= r0_r + lx_sq;
            r1_r      <= r1_nxt;
            lb_acc_r  <= lb_sub_end ? 48'h0 : lb_e;
            lb_sub_r  <= lb_sub_end ? 7'h00 : lb_sub_r + 7'h01;
            if (lb_sub_end) begin
                lb_prev_e_r <= lb_e;
                lb_det_r    <= lb_det_r || lb_hit;
            end
            lb_cnt_r  <= (lb_cnt_r == `BETD_LB_FRAME_LEN - 9'h001) ? 9'h000 : lb_cnt_r + 9'h001;
            lb_done_r <= (lb_cnt_r == `BETD_LB_FRAME_LEN - 9'h001);
        end
    end

    // Delay line of filtered upper band samples
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int i = 0; i < DELAY_SAMPLES; i++) dly_r[i] <= 18'sh0;
            mdct_valid_r <= 1'b0;
            mdct_data_r  <= 16'sh0;
        end else begin
            mdct_valid_r <= i_upper.valid && !ub_done_r && (phase_r == betd_pkg::BETD_COLLECT);
            if (i_upper.valid && !ub_done_r && (phase_r == betd_pkg::BETD_COLLECT)) begin
                dly_r[0] <= y_now;
                for (int i = 1; i < DELAY_SAMPLES; i++) dly_r[i] <= dly_r[i-1];
                mdct_data_r <= dly_r[DELAY_SAMPLES-1][17:2];
            end
        end
    end

    // Frame phase and retained frame decision
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            phase_r      <= betd_pkg::BETD_COLLECT;
            hang_r       <= 1'b0;
            prev_swb_r   <= 1'b0;
            cfg_prev_r   <= 5'h00;
            class_prev_r <= betd_pkg::BETD_NOISE_CLASS;
            done_r       <= 1'b0;
            variant_r    <= betd_pkg::BETD_VAR_NONE;
            result_r     <= '0;
        end else begin
            done_r <= 1'b0;
            case (phase_r)
                betd_pkg::BETD_COLLECT: begin
                    variant_r <= variant_nxt;
                    if (ub_done_r && lb_done_r) phase_r <= betd_pkg::BETD_DECIDE;
                end
                betd_pkg::BETD_DECIDE: begin
                    hang_r       <= hang_next;
                    prev_swb_r   <= (variant_r == betd_pkg::BETD_VAR_GUIDED_SWB);
                    cfg_prev_r   <= cfg_now;
                    class_prev_r <= class_nxt;
                    result_r     <= result_nxt;
                    done_r       <= 1'b1;
                    phase_r      <= betd_pkg::BETD_COLLECT;
                end
                default: phase_r <= betd_pkg::BETD_COLLECT;
            endcase
        end
    end

    // Output drive
    assign o_rdata         = rdata_r;
    assign o_mdct_in.valid = mdct_valid_r;
    assign o_mdct_in.data  = mdct_data_r;
    assign o_frame_done    = done_r;
    assign o_variant       = variant_r;
    assign o_result        = result_r;

endmodule : betd_detector

/* File: test/betd_detector_assertions.sv */
// Checker for the detector ports
`timescale 1ns/1ns
module betd_detector_chk (
    // Clock and reset
    input wire logic                   i_clk,
    input wire logic                   i_resetn,
    // Observed ports
    input wire logic                   i_rd,
    input wire betd_pkg::betd_sample_t i_upper,
    input wire logic [31:0]            o_rdata,
    input wire betd_pkg::betd_sample_t o_mdct_in,
    input wire logic                   o_frame_done,
    input wire betd_pkg::betd_result_t o_result
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    // Timing and holding
    property p_done; o_frame_done |=> !o_frame_done; endproperty
    a_done: assert property (p_done) else $error("done too long");
    property p_mdct; o_mdct_in.valid |-> $past(i_upper.valid); endproperty
    a_mdct: assert property (p_mdct) else $error("stray sample");
    property p_hold; !o_frame_done |-> $stable(o_result); endproperty
    a_hold: assert property (p_hold) else $error("result moved");
    // Budget split by class
    property p_total; o_result.total_bits != 5'h00 |-> o_result.total_bits == 5'h1F && o_result.class_bits == 2'h2;
    endproperty
    a_total: assert property (p_total) else $error("bad budget");
    property p_ts; o_result.frame_class == betd_pkg::BETD_TRANSIENT_CLASS |->
        o_result.spectral_envs == 4'h4 && o_result.time_envs == 3'h4; endproperty
    a_ts: assert property (p_ts) else $error("bad ts envs");
    property p_nt; o_result.total_bits != 5'h00 && o_result.frame_class != betd_pkg::BETD_TRANSIENT_CLASS |->
        o_result.spectral_envs == 4'hE && o_result.time_envs == 3'h0; endproperty
    a_nt: assert property (p_nt) else $error("bad nt envs");
    // Flag, class and veto
    property p_flag; o_result.upper_band_transient_flag |-> o_result.frame_class == betd_pkg::BETD_TRANSIENT_CLASS;
    endproperty
    a_flag: assert property (p_flag) else $error("flag w/o class");
    property p_veto; o_result.tilt_veto |-> !o_result.upper_band_transient_flag && !o_result.hangover; endproperty
    a_veto: assert property (p_veto) else $error("veto ignored");
    // Scenarios
    c_ts: cover property (o_frame_done && o_result.frame_class == betd_pkg::BETD_TRANSIENT_CLASS);
    c_veto: cover property (o_frame_done && o_result.tilt_veto);
    c_read: cover property (i_rd ##1 o_rdata != 32'h0);
endmodule : betd_detector_chk

bind betd_detector betd_detector_chk i_betd_detector_chk (.i_clk, .i_resetn, .i_rd,
    .i_upper, .o_rdata, .o_mdct_in, .o_frame_done, .o_result);

/* File: test/betd_source.sv */
// Core encoder side frame source
`timescale 1ns/1ns
module betd_source (
    // Clock, reset, start
    input  wire logic               i_clk,
    input  wire logic               i_resetn,
    input  wire logic               i_start,
    // Frame shape
    input  wire logic signed [15:0] i_quiet,
    input  wire logic signed [15:0] i_burst,
    input  wire logic signed [15:0] i_low,
    input  wire logic               i_low_alt,
    input  wire logic               i_low_step,
    // Streams out
    output betd_pkg::betd_sample_t  o_upper,
    output betd_pkg::betd_sample_t  o_lower,
    output logic                    o_busy
);
    logic [8:0]         n_r;
    logic signed [15:0] ua;
    logic signed [15:0] la;
    // Burst and step in last sub-frames
    assign ua = (n_r >= 9'h0F0) ? i_burst : i_quiet;
    assign la = (i_low_step && n_r >= 9'h0C0) ? 16'sh03E8 : i_low;
    // One sample a cycle, 256 lower
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            n_r     <= 9'h000;
            o_busy  <= 1'b0;
            o_upper <= '0;
            o_lower <= '0;
        end else if (i_start) begin
            n_r    <= 9'h000;
            o_busy <= 1'b1;
        end else if (o_busy) begin
            o_upper <= '{1'b1, n_r[0] ? -ua : ua};
            o_lower <= '{n_r < 9'h100, (i_low_alt && n_r[0]) ? -la : la};
            n_r     <= n_r + 9'h001;
            o_busy  <= n_r != 9'h13F;
        end else begin
            o_upper <= '{1'b0, ~o_upper.data};
            o_lower <= '{1'b0, ~o_lower.data};
        end
    end
endmodule : betd_source

/* File: test/betd_detector_tb.sv */
// Bench for the transient detector
`timescale 1ns/1ns
`include "betd_map.svh"
module betd_detector_tb;
    logic                    i_clk = 1'b0;
    logic                    i_resetn = 1'b1;
    logic [3:0]              i_addr = 4'h0;
    logic [31:0]             i_wdata = 32'h0;
    logic                    i_wr = 1'b0;
    logic                    i_rd = 1'b0;
    logic                    start = 1'b0;
    logic signed [15:0]      burst = 16'sh0064;
    logic signed [15:0]      low = 16'sh0064;
    logic                    low_alt = 1'b0;
    logic                    low_step = 1'b0;
    logic                    busy;
    logic [31:0]             o_rdata;
    logic [31:0]             rd_v;
    betd_pkg::betd_sample_t  i_upper;
    betd_pkg::betd_sample_t  i_lower;
    betd_pkg::betd_sample_t  o_mdct_in;
    logic                    o_frame_done;
    betd_pkg::betd_variant_t o_variant;
    betd_pkg::betd_result_t  o_result;
    int                      fails = 0;
    int                      checked = 0;
    int                      cyc = 0;

    betd_detector i_betd_detector (.i_clk, .i_resetn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_upper,
        .i_lower, .o_mdct_in, .o_frame_done, .o_variant, .o_result);
    betd_source i_betd_source (.i_clk, .i_resetn, .i_start(start), .i_quiet(16'sh0064),
        .i_burst(burst), .i_low(low), .i_low_alt(low_alt), .i_low_step(low_step), .o_upper(i_upper),
        .o_lower(i_lower), .o_busy(busy));

    // Clock and hang guard
    always #5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            end_sim;
        end
    end

    // Verdict and end of run
    task automatic end_sim;
        if (fails == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim

    // Value comparison
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    // Register bus cycles
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask : rd

    // One frame, waits for result
    task automatic frame(input logic [7:0] ctrl, input logic signed [15:0] b, input logic alt, input logic st);
        int n;
        int m = 0;
        wr(`BETD_OFS_CTRL, {24'h0, ctrl});
        burst    <= b;
        low      <= alt ? 16'sh03E8 : 16'sh0064;
        low_alt  <= alt;
        low_step <= st;
        start    <= 1'b1;
        @(posedge i_clk);
        start <= 1'b0;
        for (n = 0; n < 1000 && o_frame_done !== 1'b1; n++) begin
            @(posedge i_clk);
            #1;
            m += o_mdct_in.valid;
        end
        cmp("frame done", 32'h1, {31'h0, o_frame_done});
        cmp("mdct count", 32'(`BETD_UB_FRAME_LEN), m);
    endtask : frame

    // Result fields
    task automatic res(input logic ub, input logic [1:0] cls, input logic [3:0] sp, input logic [2:0] te);
        cmp("ub flag", {31'h0, ub}, {31'h0, o_result.upper_band_transient_flag});
        cmp("class", {30'h0, cls}, {30'h0, o_result.frame_class});
        cmp("spec envs", {28'h0, sp}, {28'h0, o_result.spectral_envs});
        cmp("time envs", {29'h0, te}, {29'h0, o_result.time_envs});
    endtask : res

    // Reset and access
    task automatic t_regs;
        cmp("result", 32'h0, {8'h0, o_result});
        rd(`BETD_OFS_CTRL, rd_v);
        cmp("ctrl", `BETD_CTRL_RESET, rd_v);
        wr(`BETD_OFS_STATUS, 32'hFFFFFFFF);
        rd(`BETD_OFS_STATUS, rd_v);
        cmp("status", 32'h0, rd_v & 32'hFFFFFF3F);
        wr(`BETD_OFS_FB_ORI, 32'h00000100);
        rd(`BETD_OFS_FB_ORI, rd_v);
        cmp("fb ori", 32'h00000100, rd_v);
        rd(4'h2, rd_v);
        cmp("unmapped", 32'h0, rd_v);
    endtask : t_regs

    // Variant select
    task automatic t_variant;
        logic [7:0] c [6] = '{8'h00, 8'h01, 8'h02, 8'h0A, 8'h0B, 8'h13};
        logic [1:0] v [6] = '{2'h1, 2'h1, 2'h2, 2'h3, 2'h3, 2'h3};
        for (int k = 0; k < 6; k++) begin
            wr(`BETD_OFS_CTRL, {24'h0, c[k]});
            @(posedge i_clk);
            #1 cmp("variant", {30'h0, v[k]}, {30'h0, o_variant});
        end
    endtask : t_variant

    // Detection and class
    task automatic t_detect;
        frame(8'h8B, 16'sh0FA0, 1'b0, 1'b0);
        res(1'b0, 2'h2, 4'hE, 3'h0);
        frame(8'h8B, 16'sh0064, 1'b0, 1'b0);
        res(1'b0, 2'h2, 4'hE, 3'h0);
        frame(8'h8B, 16'sh0FA0, 1'b0, 1'b0);
        res(1'b1, 2'h1, 4'h4, 3'h4);
        rd(`BETD_OFS_STATUS, rd_v);
        cmp("status", 32'h000044D1, rd_v & 32'hFFFFFFF7);
        frame(8'h8B, 16'sh0064, 1'b0, 1'b0);
        cmp("hangover class", 32'h1, {30'h0, o_result.frame_class});
        frame(8'hCB, 16'sh0064, 1'b0, 1'b0);
        res(1'b0, 2'h3, 4'hE, 3'h0);
    endtask : t_detect

    // Tilt veto
    task automatic t_veto;
        frame(8'hCB, 16'sh0FA0, 1'b1, 1'b0);
        res(1'b0, 2'h3, 4'hE, 3'h0);
        cmp("veto", 32'h1, {31'h0, o_result.tilt_veto});
        frame(8'h0B, 16'sh0064, 1'b0, 1'b0);
        res(1'b0, 2'h0, 4'hE, 3'h0);
    endtask : t_veto

    // Low flag, fb ratio
    task automatic t_low_fb;
        frame(8'h8B, 16'sh0064, 1'b0, 1'b1);
        cmp("lb flag", 32'h1, {31'h0, o_result.low_band_transient_flag});
        wr(`BETD_OFS_FB_SYN, 32'h00000010);
        frame(8'h93, 16'sh0064, 1'b0, 1'b0);
        cmp("lb flag", 32'h0, {31'h0, o_result.low_band_transient_flag});
        cmp("fb ratio", 32'h2, {28'h0, o_result.fullband_ratio});
    endtask : t_low_fb

    // Main sequence
    initial begin
        i_resetn <= 1'b0;
        repeat (10) @(posedge i_clk);
        i_resetn <= 1'b1;
        t_regs;
        t_variant;
        t_detect;
        t_veto;
        t_low_fb;
        end_sim;
    end
endmodule : betd_detector_tb
